/* hw/plc_measure_handshake_params.svh */
// Constants for the controller-port measure handshake block
`ifndef PLC_MEASURE_HANDSHAKE_PARAMS_SVH
`define PLC_MEASURE_HANDSHAKE_PARAMS_SVH

`define CLK_MHZ 100
`define TRIG_MIN_MS 10
`define TRIG_MIN_CYC (`TRIG_MIN_MS * 1000 * `CLK_MHZ)
`define DEBOUNCE_US 1
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define MEAS_SLOW_MS 700
`define MEAS_MED_MS 450
`define MEAS_FAST_MS 240
`define MEAS_SLOW_CYC (`MEAS_SLOW_MS * 1000 * `CLK_MHZ)
`define MEAS_MED_CYC (`MEAS_MED_MS * 1000 * `CLK_MHZ)
`define MEAS_FAST_CYC (`MEAS_FAST_MS * 1000 * `CLK_MHZ)
`define MEM_LAST 4'h9
`define FULL_SCALE_COUNT 30000
`define FULL_SCALE_MV 3000

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RESULT 4'h8
`define CTRL_ANA_EN 0
`define CTRL_INVERT 1
`define CTRL_REMOTE_SEL 3:2
`define CTRL_SPEED 5:4
`define CTRL_RST 32'h0000_0000

`endif

/* hw/plc_measure_handshake_pkg.sv */
// Types for the controller-port measure handshake block
package plc_measure_handshake_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_MEAS = 3'b010,
      ST_DONE = 3'b011,
      ST_ERR = 3'b100
   } seq_state_t;
   typedef enum logic [1:0] {
      IF_NONE = 2'b00,
      IF_CTRL_PORT = 2'b01,
      IF_SERIAL = 2'b10,
      IF_BUS = 2'b11
   } remote_if_t;
   typedef enum logic [1:0] {
      SPD_SLOW = 2'b00,
      SPD_MED = 2'b01,
      SPD_FAST = 2'b10
   } speed_t;
endpackage : plc_measure_handshake_pkg

/* hw/plc_measure_handshake.sv */
// Controller-port measure handshake: trigger, memory select, results, analogue drive
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "plc_measure_handshake_params.svh"

// Summary of operation
// - Acknowledge stays low after request until first trigger, then follows request.
// - Test-done rises when each measurement cycle finishes.
// - With limits on, at most one of pass, fail-low, fail-high rises with done; limit result 3 raises none.
// - Measurement faults raise error together with test-done.
// - Empty memory or full log raises error without test-done.
// - Keyboard is locked while the request is asserted.
// - With no remote interface chosen, request selects the controller port.
// - Serial or bus active at request gives warning and beep, keyboard locked.
// - Remote indicator follows request; release clears it and unlocks keyboard.
// - On trigger, sample memory select, load memory, then start measuring.
// - Held trigger repeats measurements; momentary trigger gives one.
// - Single-trigger only; continuous memory is forced single, memory number hidden.
// - Contacts close on assertion by default; polarity can be inverted.
// - Analogue output proportional to reading; full scale gives 3 V with sign.
// - Temperature compensation selects compensated value for analogue output.
// - Analogue output enable is off after every reset.
// - Memory select is unsigned binary 0 to 9, top input most significant.
// - Measure time is about 700, 450 or 240 ms by speed mode.
module plc_measure_handshake #(
   parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
   parameter int TRIG_MIN_CYC = `TRIG_MIN_CYC,
   parameter int MEAS_SLOW_CYC = `MEAS_SLOW_CYC,
   parameter int MEAS_MED_CYC = `MEAS_MED_CYC,
   parameter int MEAS_FAST_CYC = `MEAS_FAST_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Controller port inputs
   input wire logic i_remote_request,
   input wire logic i_measure,
   input wire logic [3:0] i_memory_select,
   // Measurement engine
   output logic o_load_memory,
   output logic [3:0] o_load_index,
   input wire logic i_load_done,
   input wire logic i_mem_empty,
   input wire logic i_mem_continuous,
   input wire logic i_log_on,
   input wire logic i_log_full,
   input wire logic i_limits_on,
   output logic o_meas_start,
   input wire logic i_meas_done,
   input wire logic i_meas_fault,
   input wire logic [1:0] i_limit_result,
   input wire logic i_tcomp_on,
   input wire logic signed [15:0] i_reading_raw,
   input wire logic signed [15:0] i_reading_comp,
   // Front panel
   output logic o_keyboard_lock,
   output logic o_remote_indicator,
   output logic o_warning,
   output logic o_beep,
   output logic o_mem_num_hide,
   output logic o_force_single,
   // Contacts
   output logic o_control_granted,
   output logic o_test_done,
   output logic o_pass,
   output logic o_fail_low,
   output logic o_fail_high,
   output logic o_error,
   // Analogue output in millivolts
   output logic o_analog_en,
   output logic signed [15:0] o_analog_mv
);

   logic [31:0] ctrl_r;
   logic [1:0] req_sync_r, meas_sync_r;
   logic [3:0] sel_s1_r, sel_s2_r;
   logic req_db_r, meas_db_r;
   logic [3:0] sel_db_r;
   logic [31:0] req_cnt_r, meas_cnt_r, sel_cnt_r;
   logic [31:0] trig_cnt_r;
   logic trig_ok_r;
   logic granted_r;
   logic [31:0] meas_cnt2_r;
   logic [31:0] meas_time;
   plc_measure_handshake_pkg::seq_state_t state_r;
   plc_measure_handshake_pkg::remote_if_t rif_r;
   logic warn_r;
   logic [23:0] beep_cnt_r;
   logic done_r, pass_r, flo_r, fhi_r, err_r, hide_r, single_r;
   logic [3:0] mem_r;
   logic [1:0] req_edge_r;

   // Two-stage synchronisers; only stage two feeds the debouncers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         req_sync_r <= 2'h0;
         meas_sync_r <= 2'h0;
         sel_s1_r <= 4'h0;
         sel_s2_r <= 4'h0;
      end else begin
         req_sync_r <= {req_sync_r[0], i_remote_request};
         meas_sync_r <= {meas_sync_r[0], i_measure};
         sel_s1_r <= i_memory_select;
         sel_s2_r <= sel_s1_r;
      end
   end

   // Debounce: input must differ from the debounced value DEBOUNCE_CYC cycles in a row
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         req_db_r <= 1'b0;
         meas_db_r <= 1'b0;
         sel_db_r <= 4'h0;
         req_cnt_r <= 32'h0;
         meas_cnt_r <= 32'h0;
         sel_cnt_r <= 32'h0;
      end else begin
         if (req_sync_r[1] == req_db_r) req_cnt_r <= 32'h0;
         else if (req_cnt_r >= 32'(DEBOUNCE_CYC - 1)) begin
            req_db_r <= req_sync_r[1];
            req_cnt_r <= 32'h0;
         end else req_cnt_r <= req_cnt_r + 32'h1;
         if (meas_sync_r[1] == meas_db_r) meas_cnt_r <= 32'h0;
         else if (meas_cnt_r >= 32'(DEBOUNCE_CYC - 1)) begin
            meas_db_r <= meas_sync_r[1];
            meas_cnt_r <= 32'h0;
         end else meas_cnt_r <= meas_cnt_r + 32'h1;
         if (sel_s2_r == sel_db_r) sel_cnt_r <= 32'h0;
         else if (sel_cnt_r >= 32'(DEBOUNCE_CYC - 1)) begin
            sel_db_r <= sel_s2_r;
            sel_cnt_r <= 32'h0;
         end else sel_cnt_r <= sel_cnt_r + 32'h1;
      end
   end

   // Trigger counts as accepted once held for the minimum width
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         trig_cnt_r <= 32'h0;
         trig_ok_r <= 1'b0;
      end else if (!meas_db_r || !req_db_r) begin
         trig_cnt_r <= 32'h0;
         trig_ok_r <= 1'b0;
      end else if (trig_cnt_r >= 32'(TRIG_MIN_CYC - 1)) begin
         trig_ok_r <= 1'b1;
      end else begin
         trig_cnt_r <= trig_cnt_r + 32'h1;
      end
   end

   // Grant waits for first accepted trigger, then follows request
   // A trigger while another remote interface owns the unit still sets trig_ok_r, but gives no grant
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         granted_r <= 1'b0;
      end else if (!req_db_r) begin
         granted_r <= 1'b0;
      end else if (trig_ok_r && rif_r == plc_measure_handshake_pkg::IF_CTRL_PORT) begin
         granted_r <= 1'b1;
      end
   end

   // Remote interface selection and conflict warning
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rif_r <= plc_measure_handshake_pkg::IF_NONE;
         warn_r <= 1'b0;
         req_edge_r <= 2'b00;
         beep_cnt_r <= 24'h0;
      end else begin
         req_edge_r <= {req_edge_r[0], req_db_r};
         beep_cnt_r <= warn_r ? beep_cnt_r + 24'h1 : 24'h0;
         if (req_db_r && !req_edge_r[0]) begin
            if (ctrl_r[`CTRL_REMOTE_SEL] == 2'(plc_measure_handshake_pkg::IF_NONE))
               rif_r <= plc_measure_handshake_pkg::IF_CTRL_PORT;
            else
               rif_r <= plc_measure_handshake_pkg::remote_if_t'(ctrl_r[`CTRL_REMOTE_SEL]);
            warn_r <= ctrl_r[3];
         end else if (!req_db_r) begin
            warn_r <= 1'b0;
            rif_r <= plc_measure_handshake_pkg::IF_NONE;
         end
      end
   end

   always_comb begin
      case (plc_measure_handshake_pkg::speed_t'(ctrl_r[`CTRL_SPEED]))
         plc_measure_handshake_pkg::SPD_MED: meas_time = 32'(MEAS_MED_CYC);
         plc_measure_handshake_pkg::SPD_FAST: meas_time = 32'(MEAS_FAST_CYC);
         default: meas_time = 32'(MEAS_SLOW_CYC);
      endcase
   end

   // Measurement sequencer; only leaves idle when the controller port owns remote
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= plc_measure_handshake_pkg::ST_IDLE;
         mem_r <= 4'h0;
         meas_cnt2_r <= 32'h0;
         done_r <= 1'b0;
         pass_r <= 1'b0;
         flo_r <= 1'b0;
         fhi_r <= 1'b0;
         err_r <= 1'b0;
         hide_r <= 1'b0;
         single_r <= 1'b0;
      end else begin
         case (state_r)
            plc_measure_handshake_pkg::ST_IDLE: begin
               if (trig_ok_r && rif_r == plc_measure_handshake_pkg::IF_CTRL_PORT) begin
                  mem_r <= sel_db_r;
                  {done_r, pass_r, flo_r, fhi_r, err_r} <= 5'h00;
                  if (sel_db_r > `MEM_LAST) state_r <= plc_measure_handshake_pkg::ST_ERR;
                  else state_r <= plc_measure_handshake_pkg::ST_LOAD;
               end
            end
            plc_measure_handshake_pkg::ST_LOAD: begin
               if (i_load_done) begin
                  if (i_mem_empty || (i_log_on && i_log_full))
                     state_r <= plc_measure_handshake_pkg::ST_ERR;
                  else begin
                     if (i_mem_continuous) begin
                        single_r <= 1'b1;
                        hide_r <= 1'b1;
                     end
                     meas_cnt2_r <= 32'h0;
                     state_r <= plc_measure_handshake_pkg::ST_MEAS;
                  end
               end
            end
            plc_measure_handshake_pkg::ST_MEAS: begin
               meas_cnt2_r <= meas_cnt2_r + 32'h1;
               // Engine done ends the cycle; timing mirrors the speed mode
               if (i_meas_done && meas_cnt2_r >= meas_time - 32'h1) begin
                  done_r <= 1'b1;
                  if (i_meas_fault) err_r <= 1'b1;
                  else if (i_limits_on) begin
                     pass_r <= i_limit_result == 2'h0;
                     flo_r <= i_limit_result == 2'h1;
                     fhi_r <= i_limit_result == 2'h2;
                  end
                  state_r <= plc_measure_handshake_pkg::ST_DONE;
               end
            end
            plc_measure_handshake_pkg::ST_DONE: begin
               // Held trigger restarts; results stay until then
               if (meas_db_r && req_db_r) begin
                  {done_r, pass_r, flo_r, fhi_r, err_r} <= 5'h00;
                  state_r <= plc_measure_handshake_pkg::ST_LOAD;
               end else state_r <= plc_measure_handshake_pkg::ST_IDLE;
            end
            plc_measure_handshake_pkg::ST_ERR: begin
               // Held until the trigger drops, so a slow controller still sees it
               err_r <= 1'b1;
               if (!meas_db_r) state_r <= plc_measure_handshake_pkg::ST_IDLE;
            end
            default: state_r <= plc_measure_handshake_pkg::ST_IDLE;
         endcase
         if (!req_db_r) hide_r <= hide_r;
      end
   end

   assign o_load_memory = state_r == plc_measure_handshake_pkg::ST_LOAD;
   assign o_load_index = mem_r;
   assign o_meas_start = state_r == plc_measure_handshake_pkg::ST_MEAS && meas_cnt2_r == 32'h0;
   assign o_keyboard_lock = req_db_r;
   assign o_remote_indicator = req_db_r;
   assign o_warning = warn_r;
   assign o_beep = warn_r && beep_cnt_r[23];
   assign o_mem_num_hide = hide_r;
   assign o_force_single = single_r;

   // Contact polarity: closed means asserted unless inverted
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_control_granted <= 1'b0;
         o_test_done <= 1'b0;
         o_pass <= 1'b0;
         o_fail_low <= 1'b0;
         o_fail_high <= 1'b0;
         o_error <= 1'b0;
      end else begin
         o_control_granted <= granted_r ^ ctrl_r[`CTRL_INVERT];
         o_test_done <= done_r ^ ctrl_r[`CTRL_INVERT];
         o_pass <= pass_r ^ ctrl_r[`CTRL_INVERT];
         o_fail_low <= flo_r ^ ctrl_r[`CTRL_INVERT];
         o_fail_high <= fhi_r ^ ctrl_r[`CTRL_INVERT];
         o_error <= err_r ^ ctrl_r[`CTRL_INVERT];
      end
   end

   // Analogue: reading scaled so full-scale count gives 3000 mV
   logic signed [15:0] ana_src;
   logic signed [31:0] ana_prod;
   assign ana_src = i_tcomp_on ? i_reading_comp : i_reading_raw;
   assign ana_prod = 32'(ana_src) * 32'sd`FULL_SCALE_MV / 32'sd`FULL_SCALE_COUNT;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) o_analog_mv <= 16'h0000;
      else if (ctrl_r[`CTRL_ANA_EN] && i_meas_done) o_analog_mv <= ana_prod[15:0];
      else if (!ctrl_r[`CTRL_ANA_EN]) o_analog_mv <= 16'h0000;
   end
   assign o_analog_en = ctrl_r[`CTRL_ANA_EN];

   // Register slave: one wait cycle on every access; a write commits only in
   // the cycle waitrequest is low, the one edge the master is bound to hold it
   logic wait_r;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) wait_r <= 1'b1;
      else if ((i_avs_read || i_avs_write) && wait_r) wait_r <= 1'b0;
      else wait_r <= 1'b1;
   end
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) ? wait_r : 1'b1;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl_r <= `CTRL_RST;
      end else if (i_avs_write && !wait_r && i_avs_address == `REG_CTRL) begin
         ctrl_r <= {26'h0, i_avs_writedata[5:0]};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) o_avs_readdata <= 32'h0000_0000;
      else if (i_avs_read && wait_r) begin
         if (i_avs_address == `REG_CTRL) o_avs_readdata <= ctrl_r;
         else if (i_avs_address == `REG_STATUS)
            o_avs_readdata <= {24'h0, granted_r, req_db_r, warn_r, state_r, rif_r};
         else if (i_avs_address == `REG_RESULT)
            o_avs_readdata <= {22'h0, hide_r, mem_r, done_r, pass_r, flo_r, fhi_r, err_r};
         else o_avs_readdata <= 32'h0000_0000;
      end
   end

endmodule : plc_measure_handshake

/* verification/plc_measure_handshake_props.sv */
// Port-level checker for the controller-port measure handshake block
`timescale 1ns/100ps
module plc_measure_handshake_props (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic o_avs_waitrequest,
   input wire logic i_remote_request,
   input wire logic o_load_memory,
   input wire logic o_meas_start,
   input wire logic o_keyboard_lock,
   input wire logic o_remote_indicator,
   input wire logic o_control_granted,
   input wire logic o_test_done,
   input wire logic o_pass,
   input wire logic o_fail_low,
   input wire logic o_fail_high,
   input wire logic o_error,
   input wire logic o_analog_en
);
   logic inv_r;
   // Contact checks pause once polarity is flipped; only a reset puts it back
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         inv_r <= 1'b0;
      end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0) begin
         inv_r <= inv_r | i_avs_writedata[1];
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   lock_release_a: assert property ((!i_remote_request) [*8] ##1 !i_remote_request |->
      !o_keyboard_lock) else $error("keyboard lock held after request dropped");
   indicator_on_a: assert property (i_remote_request [*8] ##1 i_remote_request |->
      o_remote_indicator) else $error("remote indicator missing while requested");
   analog_off_a: assert property ($fell(i_rst) |-> !o_analog_en)
      else $error("analogue output enabled after reset");
   result_onehot_a: assert property (disable iff (i_rst || inv_r)
      $onehot0({o_pass, o_fail_low, o_fail_high})) else $error("more than one result");
   result_done_a: assert property (disable iff (i_rst || inv_r)
      (o_pass || o_fail_low || o_fail_high) |-> o_test_done) else $error("result without done");
   granted_drop_a: assert property (disable iff (i_rst || inv_r)
      (!i_remote_request) [*8] ##1 !i_remote_request |-> !o_control_granted)
      else $error("acknowledge held without request");
   load_first_a: assert property (o_meas_start |-> $past(o_load_memory))
      else $error("measurement started without memory load");
   start_clears_a: assert property (disable iff (i_rst || inv_r)
      o_meas_start |=> (!o_test_done && !o_error) [*5]) else $error("outputs not cleared at start");
   cover property (o_meas_start);
   cover property ($rose(o_test_done));
   cover property ($rose(o_error) && !o_test_done);
endmodule : plc_measure_handshake_props

bind plc_measure_handshake plc_measure_handshake_props plc_measure_handshake_props_inst (.*);

/* verification/plc_controller_model.sv */
// Behavioural programmable controller driving request, trigger and memory select
`timescale 1ns/100ps
module plc_controller_model #(
   parameter int TRIG_MIN_CYC = 5
) (
   input wire logic i_clk_sys,
   output logic o_remote_request,
   output logic o_measure,
   output logic [3:0] o_memory_select
);
   initial begin
      o_remote_request = 1'b0;
      o_measure = 1'b0;
      o_memory_select = 4'hF;
   end
   task automatic request(input logic lvl);
      @(posedge i_clk_sys);
      o_remote_request <= lvl;
   endtask : request
   // Select is scrambled after release so a late sample of it is caught
   task automatic trigger(input logic [3:0] mem, input int hold);
      @(posedge i_clk_sys);
      o_memory_select <= mem;
      repeat (2) @(posedge i_clk_sys);
      o_measure <= 1'b1;
      repeat (hold < TRIG_MIN_CYC ? TRIG_MIN_CYC : hold) @(posedge i_clk_sys);
      o_measure <= 1'b0;
      o_memory_select <= ~mem;
   endtask : trigger
endmodule : plc_controller_model

/* verification/test_plc_measure_handshake.sv */
// Self-checking bench for the controller-port measure handshake block
`timescale 1ns/100ps
module test_plc_measure_handshake;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] i_avs_address = 4'h0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata, q;
   logic o_avs_waitrequest, i_remote_request, i_measure, o_load_memory, o_meas_start;
   logic [3:0] i_memory_select, o_load_index;
   logic i_load_done = 1'b0, i_mem_empty = 1'b0, i_mem_continuous = 1'b0, i_log_on = 1'b0;
   logic i_log_full = 1'b0, i_limits_on = 1'b1, i_meas_done = 1'b0, i_meas_fault = 1'b0;
   logic [1:0] i_limit_result = 2'h0;
   logic i_tcomp_on = 1'b0, eng_l = 1'b0, eng_s = 1'b0;
   logic signed [15:0] i_reading_raw = 16'sh2710;
   logic signed [15:0] i_reading_comp = 16'shB1E0;
   logic signed [15:0] o_analog_mv;
   logic o_keyboard_lock, o_remote_indicator, o_warning, o_beep, o_mem_num_hide, o_force_single;
   logic o_control_granted, o_test_done, o_pass, o_fail_low, o_fail_high, o_error, o_analog_en;
   int bad_count = 0;
   int check_count = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   // Engine stub: outputs are sampled mid-cycle so the stub never races the design
   always @(negedge i_clk_sys) begin
      eng_l = o_load_memory;
      eng_s = o_meas_start;
   end
   always @(posedge i_clk_sys) begin
      i_load_done <= eng_l;
      i_meas_done <= !eng_s;
   end
   plc_measure_handshake #(.DEBOUNCE_CYC(2), .TRIG_MIN_CYC(5), .MEAS_SLOW_CYC(10),
      .MEAS_MED_CYC(8), .MEAS_FAST_CYC(5)) plc_measure_handshake_inst (.*);
   plc_controller_model plc_controller_model_inst (.i_clk_sys(i_clk_sys),
      .o_remote_request(i_remote_request), .o_measure(i_measure),
      .o_memory_select(i_memory_select));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_writedata <= d;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      q = o_avs_readdata;
      if (n >= 50) bad_count++;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus
   task automatic wait_hi(input logic err);
      int n;
      n = 0;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while ((err ? o_error : o_test_done) !== 1'b1 && n < 200);
      if (n >= 200) bad_count++;
   endtask : wait_hi
   task automatic idle(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : idle
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   task automatic test_registers;
      bus(1'b0, 4'h0, 32'h0);
      check(q, 32'h0);
      check(32'(o_analog_en), 32'h0);
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      check(q, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      check(q, 32'h0);
      $display("test registers finished");
   endtask : test_registers
   task automatic test_request;
      plc_controller_model_inst.request(1'b1);
      idle(12);
      check(32'({o_keyboard_lock, o_remote_indicator, o_control_granted}), 32'h6);
      bus(1'b0, 4'h4, 32'h0);
      check(q, 32'h41);
      $display("test request finished");
   endtask : test_request
   task automatic test_measure;
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, 4'h0, 32'h5 | (k << 4));
         i_limit_result <= 2'(k);
         i_tcomp_on <= k[0];
         i_reading_raw <= k[1] ? 16'sh7530 : 16'sh2710;
         plc_controller_model_inst.trigger(4'(3 + k * 3), 12);
         wait_hi(1'b0);
         check(32'(o_load_index), 32'(3 + k * 3));
         check(32'({o_analog_en, o_control_granted, o_pass, o_fail_low, o_fail_high, o_error}),
            32'h30 | (32'h8 >> k));
         check(32'(o_analog_mv), k[0] ? 32'hFFFFF830 : k[1] ? 32'hBB8 : 32'h3E8);
      end
      @(posedge i_clk_sys);
      i_limits_on <= 1'b0;
      i_tcomp_on <= 1'b1;
      i_reading_comp <= 16'sh8AD0;
      plc_controller_model_inst.trigger(4'h9, 12);
      wait_hi(1'b0);
      check(32'({o_test_done, o_pass, o_fail_low, o_fail_high, o_error}), 32'h10);
      check(32'(o_analog_mv), 32'hFFFFF448);
      check(32'(o_load_index), 32'h9);
      @(posedge i_clk_sys);
      i_limits_on <= 1'b1;
      idle(60);
      $display("test measure finished");
   endtask : test_measure
   task automatic test_errors;
      for (int j = 0; j < 3; j++) begin
         @(posedge i_clk_sys);
         i_mem_empty <= (j == 0);
         i_log_on <= (j == 1);
         i_log_full <= (j == 1);
         plc_controller_model_inst.trigger(j == 2 ? 4'hA : 4'h1, 12);
         wait_hi(1'b1);
         check(32'({o_test_done, o_error}), 32'h1);
         idle(30);
      end
      @(posedge i_clk_sys);
      i_mem_empty <= 1'b0;
      i_log_on <= 1'b0;
      i_log_full <= 1'b0;
      i_meas_fault <= 1'b1;
      plc_controller_model_inst.trigger(4'h2, 12);
      wait_hi(1'b1);
      check(32'({o_test_done, o_error}), 32'h3);
      @(posedge i_clk_sys);
      i_meas_fault <= 1'b0;
      idle(30);
      $display("test errors finished");
   endtask : test_errors
   task automatic test_repeat;
      int c;
      logic p;
      c = 0;
      @(posedge i_clk_sys);
      i_mem_continuous <= 1'b1;
      p = o_test_done;
      fork
         plc_controller_model_inst.trigger(4'h7, 80);
         repeat (110) begin
            @(negedge i_clk_sys);
            if (o_test_done && !p) c++;
            p = o_test_done;
         end
      join
      check(32'(c > 1), 32'h1);
      check(32'({o_force_single, o_mem_num_hide}), 32'h3);
      @(posedge i_clk_sys);
      i_mem_continuous <= 1'b0;
      idle(30);
      $display("test repeat finished");
   endtask : test_repeat
   task automatic test_release;
      plc_controller_model_inst.request(1'b0);
      idle(12);
      check(32'({o_keyboard_lock, o_remote_indicator, o_control_granted}), 32'h0);
      bus(1'b1, 4'h0, 32'h8);
      plc_controller_model_inst.request(1'b1);
      plc_controller_model_inst.trigger(4'h2, 12);
      idle(30);
      check(32'({o_warning, o_beep, o_keyboard_lock, o_control_granted}), 32'hA);
      plc_controller_model_inst.request(1'b0);
      bus(1'b1, 4'h0, 32'h2);
      idle(5);
      check(32'({o_control_granted, o_test_done, o_pass, o_fail_low, o_fail_high, o_error}),
         32'h2D);
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus(1'b0, 4'h0, 32'h0);
      check(q, 32'h0);
      check(32'({o_analog_en, o_control_granted, o_test_done}), 32'h0);
      $display("test release finished");
   endtask : test_release
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      test_registers;
      test_request;
      test_measure;
      test_errors;
      test_repeat;
      test_release;
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      bad_count++;
      print_verdict;
   end
endmodule : test_plc_measure_handshake
